// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench
  import wwd_pkg::*;
;
  // ------------
  // Setup
  // ------------
  localparam int WIN = 20;
  localparam int INIT = 100;
  localparam logic [15:0] CFG_A = BLOCKING_BASE + 16'(CFG_OFFSET);
  localparam logic [15:0] CFG_N = NONBLOCKING_BASE + 16'(CFG_OFFSET);
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_normal_mode = 1'b1;
  logic i_test_disable = 1'b0;
  logic i_wr, i_rd, o_wdg_reset;
  logic [15:0] i_addr;
  logic [7:0] i_wdata, o_rdata, rd;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  int resets = 0;
  int r0;
  `define CHK(what, exp, got) begin total_checks++; if ((got) !== (exp)) begin fails++; \
    $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); end end

  wwd_top #(.WIN_BASE_CYCLES(WIN), .INIT_CYCLES(INIT)) uut (.i_clk(i_clk),
    .i_nrst(i_nrst), .i_normal_mode(i_normal_mode), .i_test_disable(i_test_disable),
    .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .o_wdg_reset(o_wdg_reset));
  wwd_host_model host (.i_clk(i_clk), .i_rdata(o_rdata), .o_wr(i_wr), .o_rd(i_rd),
    .o_addr(i_addr), .o_wdata(i_wdata));

  // 20 MHz base clock
  always #25 i_clk = ~i_clk;

  // Count reset pulses at the falling edge, where the registered output has settled;
  // sampling on the launching edge would race the check tasks. The ceiling cuts a hang short
  always @(negedge i_clk) begin
    cyc++;
    if (o_wdg_reset === 1'b1) resets++;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end

  // ------------
  // Helpers
  // ------------
  task automatic idle(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // Waits for the next reset pulse; its delay must fall in lo..hi
  task automatic expect_reset(input int lo, input int hi);
    int start, n;
    start = resets;
    n = 0;
    while (resets == start && n <= hi) begin
      @(posedge i_clk);
      n++;
    end
    `CHK("reset delay", 1'b1, (n >= lo && n <= hi))
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ------------
  // Main sequence
  // ------------
  initial begin
    idle(12);
    i_nrst <= 1'b1;
    idle(6);
    host.read_reg(CFG_A, rd);
    `CHK("cfg after reset", 8'h40, rd)
    host.read_reg(CFG_N, rd);
    `CHK("cfg nonblocking", 8'h40, rd)
    host.read_reg(16'h0220, rd);
    `CHK("unmapped", 8'h00, rd)
    host.write_reg(CFG_A, 8'hff);
    host.read_reg(CFG_A, rd);
    `CHK("cfg fields", 8'h47, rd)
    expect_reset(INIT - 30, INIT + 10);
    host.write_reg(CFG_A, 8'h01);
    host.service(8'h55);
    expect_reset(0, 3);
    // Arm, then watch the window open at half of a 40-cycle period
    host.service(CODE_FIRST);
    idle(8);
    host.read_reg(CFG_A, rd);
    `CHK("closed half", 8'h01, rd)
    idle(12);
    host.read_reg(CFG_A, rd);
    `CHK("open half", 8'h41, rd)
    r0 = resets;
    host.service(CODE_SECOND);
    host.read_reg(CFG_A, rd);
    `CHK("restart closed", 8'h01, rd)
    `CHK("accepted write", r0, resets)
    idle(20);
    host.service(CODE_SECOND);
    expect_reset(0, 3);
    host.service(CODE_FIRST);
    idle(3);
    host.service(CODE_SECOND);
    expect_reset(0, 3);
    // Expiry for every select code
    for (int s = 0; s < 8; s++) begin
      host.write_reg(CFG_A, 8'(s));
      host.service(CODE_FIRST);
      expect_reset((WIN << s) - 3, (WIN << s) + 4);
    end
    // Debug disable: no timing, service writes ignored, initial sequence after
    i_test_disable <= 1'b1;
    idle(4);
    host.read_reg(CFG_A, rd);
    `CHK("disabled flag", 1'b1, rd[7])
    r0 = resets;
    host.service(8'h55);
    idle(INIT + 20);
    `CHK("disabled quiet", r0, resets)
    i_test_disable <= 1'b0;
    idle(4);
    host.read_reg(CFG_A, rd);
    `CHK("re-enabled", 2'b01, rd[7:6])
    host.service(8'h55);
    expect_reset(0, 3);
    // Low power: halted, service state dropped
    host.service(CODE_FIRST);
    i_normal_mode <= 1'b0;
    idle(4);
    host.read_reg(CFG_A, rd);
    `CHK("stop read", 1'b1, rd[7])
    r0 = resets;
    idle(INIT + 20);
    `CHK("low power quiet", r0, resets)
    i_normal_mode <= 1'b1;
    idle(4);
    host.read_reg(CFG_A, rd);
    `CHK("after wake", 2'b01, rd[7:6])
    host.service(8'h55);
    expect_reset(0, 3);
    complete_run();
  end
endmodule
`default_nettype wire

// [wwd_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Controller model driving the register bus of the watchdog
module wwd_host_model
  import wwd_pkg::*;
(
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  output logic o_wr,
  output logic o_rd,
  output logic [15:0] o_addr,
  output logic [7:0] o_wdata
);
  // ------------
  // Bus cycles
  // ------------
  // Idle bus at time zero
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 16'h0000;
    o_wdata = 8'h00;
  end

  // One write; released lines show the inverse so stale data never looks valid
  task automatic write_reg(input logic [15:0] addr, input logic [7:0] data);
    @(posedge i_clk);
    o_wr <= 1'b1;
    o_addr <= addr;
    o_wdata <= data;
    @(posedge i_clk);
    o_wr <= 1'b0;
    o_addr <= ~addr;
    o_wdata <= ~data;
  endtask

  // One read; data taken once the registered answer has surely landed
  task automatic read_reg(input logic [15:0] addr, output logic [7:0] data);
    @(posedge i_clk);
    o_rd <= 1'b1;
    o_addr <= addr;
    @(posedge i_clk);
    o_rd <= 1'b0;
    o_addr <= ~addr;
    @(posedge i_clk);
    #1;
    data = i_rdata;
  endtask

  // Service code write through the blocking base
  task automatic service(input logic [7:0] code);
    write_reg(BLOCKING_BASE + 16'(SVC_OFFSET), code);
  endtask
endmodule
`default_nettype wire

// [wwd_pkg.sv]
`default_nettype none
package wwd_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int WIN_BASE_MS = 10;
  localparam int INIT_TIMEOUT_MS = 100;
  // Longest times, so the division rounds down
  localparam int WIN_BASE_CYC = WIN_BASE_MS * (CLK_HZ / 1000);
  localparam int INIT_CYC = INIT_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int CNT_W = 26;

  // ----------------------------------------
  // Address map
  // ----------------------------------------
  localparam logic [15:0] BLOCKING_BASE = 16'h0200;
  localparam logic [15:0] NONBLOCKING_BASE = 16'h0300;
  localparam logic [7:0] CFG_OFFSET = 8'h10;
  localparam logic [7:0] SVC_OFFSET = 8'h11;

  // ----------------------------------------
  // Field layout and codes
  // ----------------------------------------
  localparam int CFG_OFF_BIT = 7;
  localparam int CFG_WO_BIT = 6;
  localparam logic [2:0] CFG_SEL_RESET = 3'h0;
  localparam logic [7:0] CODE_FIRST = 8'haa;
  localparam logic [7:0] CODE_SECOND = 8'h55;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_INIT,
    ST_WINDOW
  } wwd_state_e;
endpackage
`default_nettype wire

// [wwd_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module wwd_timer
  import wwd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_clear,
  input wire logic i_run,
  input wire logic [CNT_W-1:0] i_limit,
  output logic [CNT_W-1:0] o_count,
  output logic o_half,
  output logic o_expired
);
  // ----------------------------------------
  // Period counter
  // ----------------------------------------
  // Runs only on the base clock, so bus clock gaps never stretch it
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_count <= '0;
    end else if (i_clear) begin
      o_count <= '0;
    end else if (i_run && !o_expired) begin
      o_count <= o_count + 1'b1;
    end
  end

  // Second half of the period and the last cycle
  assign o_half = o_count >= (i_limit >> 1);
  assign o_expired = i_run && (o_count >= i_limit - 1'b1);
endmodule
`default_nettype wire

// [wwd_top.sv]
`timescale 1ns/1ps
`default_nettype none
module wwd_top
  import wwd_pkg::*;
#(
  parameter int WIN_BASE_CYCLES = WIN_BASE_CYC,
  parameter int INIT_CYCLES = INIT_CYC
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_normal_mode,
  input wire logic i_test_disable,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_wdg_reset
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Either global window reaches the same register
  function automatic logic hits(input logic [15:0] addr, input logic [7:0] off);
    hits = (addr == BLOCKING_BASE + {8'h00, off}) ||
           (addr == NONBLOCKING_BASE + {8'h00, off});
  endfunction

  // Period doubles per select step
  function automatic logic [CNT_W-1:0] period(input logic [2:0] sel);
    period = CNT_W'(WIN_BASE_CYCLES) << sel;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic norm_meta;
  logic norm_s;
  logic dis_meta;
  logic dis_s;

  // Mode and debug level arrive asynchronously
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      norm_meta <= 1'b0;
      norm_s <= 1'b0;
      dis_meta <= 1'b0;
      dis_s <= 1'b0;
    end else begin
      norm_meta <= i_normal_mode;
      norm_s <= norm_meta;
      dis_meta <= i_test_disable;
      dis_s <= dis_meta;
    end
  end

  // ----------------------------------------
  // Decode and state
  // ----------------------------------------
  wwd_state_e state;
  wwd_state_e next_state;
  logic [7:0] expect_code;
  logic [7:0] next_expect;
  logic [2:0] timeout_select;
  logic next_fault;
  logic tmr_clear;
  logic active;
  logic svc_wr;
  logic cfg_wr;
  logic cfg_rd;
  logic win_open;
  logic disabled_flag;
  logic [CNT_W-1:0] tmr_limit;
  logic [CNT_W-1:0] tmr_count;
  logic tmr_half;
  logic tmr_expired;

  assign active = norm_s && !dis_s;
  assign disabled_flag = !active;
  assign svc_wr = i_wr && hits(i_addr, SVC_OFFSET);
  assign cfg_wr = i_wr && hits(i_addr, CFG_OFFSET);
  assign cfg_rd = i_rd && hits(i_addr, CFG_OFFSET);

  // Initial phase ignores the select, window phase uses it
  assign tmr_limit = (state == ST_INIT) ? CNT_W'(INIT_CYCLES) : period(timeout_select);

  // Flag is forced set in the initial phase
  always_comb begin
    case (state)
      ST_INIT: win_open = 1'b1;
      ST_WINDOW: win_open = tmr_half;
      default: win_open = 1'b0;
    endcase
  end

  // Service sequence decisions
  always_comb begin
    next_state = state;
    next_expect = expect_code;
    next_fault = 1'b0;
    tmr_clear = 1'b0;
    if (!active) begin
      next_state = ST_OFF;
      next_expect = CODE_FIRST;
      tmr_clear = 1'b1;
    end else begin
      case (state)
        ST_OFF: begin
          next_state = ST_INIT;
          tmr_clear = 1'b1;
        end
        ST_INIT: begin
          if (svc_wr) begin
            if (i_wdata == CODE_FIRST) begin
              next_state = ST_WINDOW;
              next_expect = CODE_SECOND;
            end else begin
              next_fault = 1'b1;
            end
          end else if (tmr_expired) begin
            next_fault = 1'b1;
          end
        end
        ST_WINDOW: begin
          if (svc_wr) begin
            if (!tmr_half || i_wdata != expect_code) begin
              next_fault = 1'b1;
            end else begin
              next_expect = (expect_code == CODE_FIRST) ? CODE_SECOND : CODE_FIRST;
            end
          end else if (tmr_expired) begin
            next_fault = 1'b1;
          end
        end
        default: begin
          next_state = ST_OFF;
        end
      endcase
      // After a fault the device restarts in the initial phase
      if (next_fault) begin
        next_state = ST_INIT;
        next_expect = CODE_FIRST;
      end
      // Any service write here restarts timing, accepted or not
      tmr_clear = tmr_clear || next_fault || (svc_wr && state != ST_OFF);
    end
  end

  // Sequence state
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= ST_OFF;
      expect_code <= CODE_FIRST;
    end else begin
      state <= next_state;
      expect_code <= next_expect;
    end
  end

  // Reset request, one cycle per violation
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_wdg_reset <= 1'b0;
    end else begin
      o_wdg_reset <= next_fault;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Select is writable at any time; initial phase ignores it
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      timeout_select <= CFG_SEL_RESET;
    end else if (cfg_wr) begin
      timeout_select <= i_wdata[2:0];
    end
  end

  // Service register is write only and reads zero
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      if (cfg_rd) begin
        o_rdata <= {disabled_flag, win_open, 3'h0, timeout_select};
      end else begin
        o_rdata <= 8'h00;
      end
    end
  end

  // ----------------------------------------
  // Period timer
  // ----------------------------------------
  wwd_timer u_timer (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_clear(tmr_clear),
    .i_run(active && state != ST_OFF),
    .i_limit(tmr_limit),
    .o_count(tmr_count),
    .o_half(tmr_half),
    .o_expired(tmr_expired)
  );

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence s_svc_in(wwd_state_e st);
    active && state == st && svc_wr;
  endsequence

  sequence s_good_open;
    s_svc_in(ST_WINDOW) ##0 (tmr_half && i_wdata == expect_code);
  endsequence

  property p_lowpower;
    @(posedge i_clk) disable iff (!i_nrst)
      !norm_s |=> state == ST_OFF && tmr_count == '0;
  endproperty
  a_lowpower: assert property (p_lowpower) else $error("low power not halting");

  property p_debug_off;
    @(posedge i_clk) disable iff (!i_nrst)
      dis_s |=> state == ST_OFF && expect_code == CODE_FIRST;
  endproperty
  a_debug_off: assert property (p_debug_off) else $error("debug disable ignored");

  property p_init_open;
    @(posedge i_clk) disable iff (!i_nrst)
      state == ST_INIT |-> win_open && tmr_limit == CNT_W'(INIT_CYCLES);
  endproperty
  a_init_open: assert property (p_init_open) else $error("initial phase wrong");

  property p_arm;
    @(posedge i_clk) disable iff (!i_nrst)
      s_svc_in(ST_INIT) ##0 (i_wdata == CODE_FIRST) |=>
        state == ST_WINDOW && expect_code == CODE_SECOND && !o_wdg_reset;
  endproperty
  a_arm: assert property (p_arm) else $error("first code did not arm");

  property p_bad_first;
    @(posedge i_clk) disable iff (!i_nrst)
      s_svc_in(ST_INIT) ##0 (i_wdata != CODE_FIRST) |=> o_wdg_reset ##1 !o_wdg_reset;
  endproperty
  a_bad_first: assert property (p_bad_first) else $error("bad first code kept");

  property p_closed;
    @(posedge i_clk) disable iff (!i_nrst)
      s_svc_in(ST_WINDOW) ##0 !tmr_half |=> o_wdg_reset && state == ST_INIT;
  endproperty
  a_closed: assert property (p_closed) else $error("closed window write kept");

  property p_clear;
    @(posedge i_clk) disable iff (!i_nrst)
      s_good_open |=> tmr_count == '0 && !o_wdg_reset && !win_open;
  endproperty
  a_clear: assert property (p_clear) else $error("good service not clearing");

  property p_window_expire;
    @(posedge i_clk) disable iff (!i_nrst)
      active && state == ST_WINDOW && tmr_expired && !svc_wr |=> o_wdg_reset;
  endproperty
  a_window_expire: assert property (p_window_expire) else $error("window timeout missed");

  property p_ignore_off;
    @(posedge i_clk) disable iff (!i_nrst)
      !active && svc_wr |=> !o_wdg_reset && expect_code == CODE_FIRST;
  endproperty
  a_ignore_off: assert property (p_ignore_off) else $error("write acted while off");

  property p_cfg_read;
    @(posedge i_clk) disable iff (!i_nrst)
      cfg_rd |=> o_rdata[5:3] == 3'h0 && o_rdata[CFG_OFF_BIT] == $past(disabled_flag)
        && o_rdata[CFG_WO_BIT] == $past(win_open) && o_rdata[2:0] == $past(timeout_select);
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config read wrong");
endmodule
`default_nettype wire
